// File: include/pab_pkg.sv
// Package of constants for the two-port data path block
package pab_pkg;
    localparam int unsigned PAB_PORT_W     = 8;
    localparam int unsigned PAB_ADDR_W     = 12;
    // Register indices as printed; byte address is four times the index
    localparam logic [PAB_ADDR_W-1:0] PAB_IDX_A_DATA = 12'h000;
    localparam logic [PAB_ADDR_W-1:0] PAB_IDX_B_DATA = 12'h001;
    localparam logic [PAB_ADDR_W-1:0] PAB_IDX_A_DIR  = 12'h002;
    localparam logic [PAB_ADDR_W-1:0] PAB_IDX_B_DIR  = 12'h003;
    // Reset values
    localparam logic [7:0] PAB_DATA_RST = 8'h00;
    localparam logic [7:0] PAB_DIR_RST  = 8'h00;
    // Field positions of the special Port A pins
    localparam int unsigned PAB_BIT_CLKOUT = 3;
    localparam int unsigned PAB_BIT_NMI    = 1;
    localparam int unsigned PAB_BIT_IRQ    = 0;
    // Synchroniser depth for pin inputs
    localparam int unsigned PAB_SYNC_STAGES = 2;
endpackage

// File: logic/pab_port_ab_data_path.sv
// Data-register path for two 8-bit general-purpose ports with APB access
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pab_port_ab_data_path #(
    parameter int unsigned PORT_W = pab_pkg::PAB_PORT_W
) (
    // Clock and reset
    input  wire logic                          clk,
    input  wire logic                          srst,
    // APB slave
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [pab_pkg::PAB_ADDR_W-1:0] paddr,
    input  wire logic [31:0]                   pwdata,
    input  wire logic [3:0]                    pstrb,
    output var  logic [31:0]                   prdata,
    output var  logic                          pready,
    output var  logic                          pslverr,
    // First port pins
    input  wire logic [PORT_W-1:0]             firstPortBitsIn,
    output var  logic [PORT_W-1:0]             firstPortBitsOut,
    output var  logic [PORT_W-1:0]             firstPortBitsOe,
    // Second port pins
    input  wire logic [PORT_W-1:0]             secondPortBitsIn,
    output var  logic [PORT_W-1:0]             secondPortBitsOut,
    output var  logic [PORT_W-1:0]             secondPortBitsOe,
    // LCD segment driver
    input  wire logic [PORT_W-1:0]             lcdSegEnA,
    input  wire logic [PORT_W-1:0]             lcdSegOutA,
    input  wire logic [PORT_W-1:0]             lcdSegEnB,
    input  wire logic [PORT_W-1:0]             lcdSegOutB,
    // Other alternative functions on Port A
    input  wire logic                          periodicTimerClockOutputEn,
    input  wire logic                          periodicTimerClockOutput,
    input  wire logic                          nonmaskableInterruptInputEn,
    input  wire logic                          irqInputEn,
    output var  logic                          nonmaskableInterruptInput,
    output var  logic                          irqInput
);
    import pab_pkg::*;

    logic [PORT_W-1:0] firstPortData;
    logic [PORT_W-1:0] secondPortData;
    logic [PORT_W-1:0] firstPortDirection;
    logic [PORT_W-1:0] secondPortDirection;
    logic [PORT_W-1:0] syncA1;
    logic [PORT_W-1:0] syncA2;
    logic [PORT_W-1:0] syncB1;
    logic [PORT_W-1:0] syncB2;
    logic              setupPhase;
    logic              wrStrobe;
    logic [PAB_ADDR_W-1:0] regIdx;
    logic              idxHit;
    logic [PORT_W-1:0] next_outA;
    logic [PORT_W-1:0] next_oeA;
    logic [PORT_W-1:0] next_outB;
    logic [PORT_W-1:0] next_oeB;
    logic [PORT_W-1:0] next_dataA;
    logic [PORT_W-1:0] next_dataB;
    logic [PORT_W-1:0] next_dirA;
    logic [PORT_W-1:0] next_dirB;
    logic [31:0]       rdValue;
    logic              wrHit;
    logic              clkOwnsA3;
    logic              nmiOwnsA1;
    logic              irqOwnsA0;

    // Read value: stored bit for outputs, synchronised pin for inputs
    function automatic logic [PORT_W-1:0] readMix(
        input logic [PORT_W-1:0] data,
        input logic [PORT_W-1:0] dir,
        input logic [PORT_W-1:0] pins
    );
        readMix = (dir & data) | (~dir & pins);
    endfunction

    // Byte address falls on a word boundary
    function automatic logic wordAligned(
        input logic [PAB_ADDR_W-1:0] addr
    );
        wordAligned = (addr[1:0] == 2'b00);
    endfunction

    // Enabled segments put their drive value on the pin
    function automatic logic [PORT_W-1:0] segOut(
        input logic [PORT_W-1:0] pinVal,
        input logic [PORT_W-1:0] segEn,
        input logic [PORT_W-1:0] segVal
    );
        segOut = (segEn & segVal) | (~segEn & pinVal);
    endfunction

    // Enabled segments switch the digital output driver off
    function automatic logic [PORT_W-1:0] segOe(
        input logic [PORT_W-1:0] oeVal,
        input logic [PORT_W-1:0] segEn
    );
        segOe = oeVal & ~segEn;
    endfunction

    // Bus decode; registers sit on aligned words, index is address over four
    assign setupPhase = psel && !penable;
    assign wrStrobe   = psel && penable && pready && pwrite && pstrb[0];
    assign regIdx     = {2'b00, paddr[PAB_ADDR_W-1:2]};
    assign idxHit     = wordAligned(paddr) && (regIdx <= PAB_IDX_B_DIR);
    assign wrHit      = wrStrobe && wordAligned(paddr);

    // Alternative function ownership on Port A; an enabled segment beats all
    assign clkOwnsA3 = periodicTimerClockOutputEn && !lcdSegEnA[PAB_BIT_CLKOUT];
    assign nmiOwnsA1 = nonmaskableInterruptInputEn && !lcdSegEnA[PAB_BIT_NMI];
    assign irqOwnsA0 = irqInputEn && !lcdSegEnA[PAB_BIT_IRQ];

    // One access cycle: ready is raised for the cycle after setup
    always_ff @(posedge clk) begin
        if (srst) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready  <= setupPhase;
            pslverr <= setupPhase && !idxHit;
        end
    end

    // Read value of the addressed register; refused addresses read zero
    always_comb begin
        rdValue = 32'h0000_0000;
        if (idxHit) begin
            unique case (regIdx)
                PAB_IDX_A_DATA: rdValue[PORT_W-1:0] =
                    readMix(firstPortData, firstPortDirection, syncA2);
                PAB_IDX_B_DATA: rdValue[PORT_W-1:0] =
                    readMix(secondPortData, secondPortDirection, syncB2);
                PAB_IDX_A_DIR:  rdValue[PORT_W-1:0] = firstPortDirection;
                PAB_IDX_B_DIR:  rdValue[PORT_W-1:0] = secondPortDirection;
                default:        rdValue = 32'h0000_0000;
            endcase
        end
    end

    // Read data captured in the setup cycle and held until the next setup
    always_ff @(posedge clk) begin
        if (srst) begin
            prdata <= 32'h0000_0000;
        end else if (setupPhase) begin
            prdata <= pwrite ? 32'h0000_0000 : rdValue;
        end
    end

    // Register values after this edge; pins follow them at the same edge,
    // which keeps a direction change within the two-clock read lag
    always_comb begin
        next_dataA = firstPortData;
        next_dataB = secondPortData;
        next_dirA  = firstPortDirection;
        next_dirB  = secondPortDirection;
        if (wrHit) begin
            unique case (regIdx)
                PAB_IDX_A_DATA: begin
                    next_dataA = pwdata[PORT_W-1:0];
                end
                PAB_IDX_B_DATA: begin
                    next_dataB = pwdata[PORT_W-1:0];
                end
                PAB_IDX_A_DIR: begin
                    next_dirA = pwdata[PORT_W-1:0];
                end
                PAB_IDX_B_DIR: begin
                    next_dirB = pwdata[PORT_W-1:0];
                end
                default: begin
                    // Unmapped index: nothing is written
                end
            endcase
        end
    end

    // Data registers, written at the completing access edge
    always_ff @(posedge clk) begin
        if (srst) begin
            firstPortData  <= PORT_W'(PAB_DATA_RST);
            secondPortData <= PORT_W'(PAB_DATA_RST);
        end else begin
            firstPortData  <= next_dataA;
            secondPortData <= next_dataB;
        end
    end

    // Direction registers
    always_ff @(posedge clk) begin
        if (srst) begin
            firstPortDirection  <= PORT_W'(PAB_DIR_RST);
            secondPortDirection <= PORT_W'(PAB_DIR_RST);
        end else begin
            firstPortDirection  <= next_dirA;
            secondPortDirection <= next_dirB;
        end
    end

    // Port A two-stage pin synchroniser; reads see pins two clocks late
    always_ff @(posedge clk) begin
        if (srst) begin
            syncA1 <= '0;
            syncA2 <= '0;
        end else begin
            syncA1 <= firstPortBitsIn;
            syncA2 <= syncA1;
        end
    end

    // Port B two-stage pin synchroniser
    always_ff @(posedge clk) begin
        if (srst) begin
            syncB1 <= '0;
            syncB2 <= '0;
        end else begin
            syncB1 <= secondPortBitsIn;
            syncB2 <= syncB1;
        end
    end

    // Port A pin mux: GPIO, then special functions, then LCD on top
    always_comb begin
        next_outA = next_dataA;
        next_oeA  = next_dirA;
        if (clkOwnsA3) begin
            next_outA[PAB_BIT_CLKOUT] = periodicTimerClockOutput;
            next_oeA[PAB_BIT_CLKOUT]  = 1'b1;
        end
        if (nmiOwnsA1) begin
            next_oeA[PAB_BIT_NMI] = 1'b0;
        end
        if (irqOwnsA0) begin
            next_oeA[PAB_BIT_IRQ] = 1'b0;
        end
        next_outA = segOut(next_outA, lcdSegEnA, lcdSegOutA);
        next_oeA  = segOe(next_oeA, lcdSegEnA);
    end

    // Port B pin mux: GPIO unless its LCD segment is enabled
    always_comb begin
        next_outB = segOut(next_dataB, lcdSegEnB, lcdSegOutB);
        next_oeB  = segOe(next_dirB, lcdSegEnB);
    end

    // Registered Port A pin drive
    always_ff @(posedge clk) begin
        if (srst) begin
            firstPortBitsOut <= '0;
            firstPortBitsOe  <= '0;
        end else begin
            firstPortBitsOut <= next_outA;
            firstPortBitsOe  <= next_oeA;
        end
    end

    // Registered Port B pin drive
    always_ff @(posedge clk) begin
        if (srst) begin
            secondPortBitsOut <= '0;
            secondPortBitsOe  <= '0;
        end else begin
            secondPortBitsOut <= next_outB;
            secondPortBitsOe  <= next_oeB;
        end
    end

    // Non-maskable input level, handed on only while its function owns the pin
    always_ff @(posedge clk) begin
        if (srst) begin
            nonmaskableInterruptInput <= 1'b0;
        end else begin
            nonmaskableInterruptInput <= nmiOwnsA1 && syncA2[PAB_BIT_NMI];
        end
    end

    // Maskable request level, handed on only while its function owns the pin
    always_ff @(posedge clk) begin
        if (srst) begin
            irqInput <= 1'b0;
        end else begin
            irqInput <= irqOwnsA0 && syncA2[PAB_BIT_IRQ];
        end
    end

endmodule
`default_nettype wire

// File: test/pab_pin_model.sv
// Model of the outside circuitry on one port's pins
`timescale 1ns/1ps
`default_nettype none
module pab_pin_model (
    // Block side of the pins
    input  wire logic [7:0] oe,
    input  wire logic [7:0] drv,
    // Level held outside
    input  wire logic [7:0] ext,
    output var  logic [7:0] pin
);
    // Driven pins follow the block, released pins show the outside level
    always_comb pin = (oe & drv) | (~oe & ext);
endmodule
`default_nettype wire

// File: test/pab_port_ab_data_path_asserts.sv
// Checker for the two-port data path block
`timescale 1ns/1ps
`default_nettype none
module pab_port_ab_data_path_asserts #(
    parameter int unsigned PORT_W = 8
) (
    // Clock, reset and handshake
    input wire logic              clk,
    input wire logic              srst,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic              pready,
    // Pins and alternative functions
    input wire logic [PORT_W-1:0] firstPortBitsOe,
    input wire logic [PORT_W-1:0] firstPortBitsOut,
    input wire logic [PORT_W-1:0] secondPortBitsOut,
    input wire logic [PORT_W-1:0] lcdSegEnA,
    input wire logic [PORT_W-1:0] lcdSegEnB,
    input wire logic [PORT_W-1:0] lcdSegOutB,
    input wire logic              periodicTimerClockOutputEn,
    input wire logic              periodicTimerClockOutput,
    input wire logic              nonmaskableInterruptInputEn,
    input wire logic              nonmaskableInterruptInput,
    input wire logic              irqInputEn
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (srst);
    a_ready_next: assert property (psel && !penable |=> pready)
        else $error("no answer after setup");
    a_ready_single: assert property (pready |=> !pready)
        else $error("answer longer than one cycle");
    a_lcd_a_off: assert property (1'b1 |=> (firstPortBitsOe & $past(lcdSegEnA)) == '0)
        else $error("segment pin still driven");
    a_lcd_b_out: assert property (1'b1 |=> ((secondPortBitsOut ^ $past(lcdSegOutB))
        & $past(lcdSegEnB)) == '0) else $error("segment value not on pin");
    a_clk_out_a3: assert property (!lcdSegEnA[3] && periodicTimerClockOutputEn |=>
        firstPortBitsOe[3] && firstPortBitsOut[3] == $past(periodicTimerClockOutput))
        else $error("clock output not on pin");
    a_nmi_owns: assert property (!lcdSegEnA[1] && nonmaskableInterruptInputEn
        |=> !firstPortBitsOe[1]) else $error("interrupt pin driven");
    a_nmi_lcd: assert property (lcdSegEnA[1] |=> !nonmaskableInterruptInput)
        else $error("interrupt input seen under segment");
    a_irq_owns: assert property (!lcdSegEnA[0] && irqInputEn |=> !firstPortBitsOe[0])
        else $error("request pin driven");
endmodule
bind pab_port_ab_data_path pab_port_ab_data_path_asserts #(.PORT_W(PORT_W)) u_chk (.clk,
    .srst, .psel, .penable, .pready, .firstPortBitsOe, .firstPortBitsOut, .secondPortBitsOut,
    .lcdSegEnA, .lcdSegEnB, .lcdSegOutB, .periodicTimerClockOutputEn,
    .periodicTimerClockOutput, .nonmaskableInterruptInputEn, .nonmaskableInterruptInput,
    .irqInputEn);
`default_nettype wire

// File: test/pab_port_ab_data_path_tb_top.sv
// Testbench for the two-port data path block
`timescale 1ns/1ps
`default_nettype none
module pab_port_ab_data_path_tb_top;
    import pab_pkg::*;
    logic clk = 0, srst = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, nmiIn, irqIn;
    logic [11:0] paddr = '0;
    logic [31:0] pwdata = '0, prdata, rd;
    logic [3:0] pstrb = '0;
    logic [7:0] aIn, aOut, aOe, bIn, bOut, bOe, extA = '0, segEnA = '0, segEnB = '0, segOutB = '0;
    logic er, clkOutEn = 0, clkOut = 0, nmiEn = 0, irqEn = 0;
    logic [7:0] segOutA = '0;
    int mismatches = 0, num_checks = 0, cycles = 0;
    always #12.5 clk = ~clk;
    pab_port_ab_data_path DUT (.clk, .srst, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
        .prdata, .pready, .pslverr, .firstPortBitsIn(aIn), .firstPortBitsOut(aOut),
        .firstPortBitsOe(aOe), .secondPortBitsIn(bIn), .secondPortBitsOut(bOut),
        .secondPortBitsOe(bOe), .lcdSegEnA(segEnA), .lcdSegOutA(segOutA), .lcdSegEnB(segEnB),
        .lcdSegOutB(segOutB), .periodicTimerClockOutputEn(clkOutEn),
        .periodicTimerClockOutput(clkOut), .nonmaskableInterruptInputEn(nmiEn),
        .irqInputEn(irqEn), .nonmaskableInterruptInput(nmiIn), .irqInput(irqIn));
    pab_pin_model pinA (.oe(aOe), .drv(aOut), .ext(extA), .pin(aIn));
    pab_pin_model pinB (.oe(bOe), .drv(bOut), .ext(8'h00), .pin(bIn));
    // Compare and count
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
    endtask
    // One APB transfer, held until pready is sampled high
    task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= {idx[9:0], 2'b00};
        pwdata <= {24'h0, d};
        pstrb <= 4'h1;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdchk(input logic [11:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        chk(rd, {24'h0, exp});
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    // Cut a hang short
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            mismatches++;
            results;
        end
    end
    initial begin
        cyc(20);
        srst <= 1'b0;
        apb(1'b1, PAB_IDX_A_DIR, 8'hff);
        apb(1'b1, PAB_IDX_B_DIR, 8'hff);
        rdchk(PAB_IDX_A_DATA, PAB_DATA_RST);
        rdchk(PAB_IDX_B_DATA, PAB_DATA_RST);
        apb(1'b1, PAB_IDX_A_DATA, 8'ha5);
        apb(1'b1, PAB_IDX_B_DATA, 8'h3c);
        rdchk(PAB_IDX_A_DATA, 8'ha5);
        rdchk(PAB_IDX_B_DATA, 8'h3c);
        chk({aOe, aOut, bOe, bOut}, 32'hffa5ff3c);
        extA <= 8'h5b;
        apb(1'b1, PAB_IDX_A_DIR, 8'h0f);
        cyc(3);
        rdchk(PAB_IDX_A_DATA, 8'h55);
        chk({16'h0, aOe, aIn}, {16'h0, 8'h0f, 8'h55});
        apb(1'b1, PAB_IDX_B_DIR, 8'h0f);
        cyc(3);
        rdchk(PAB_IDX_B_DATA, 8'h0c);
        rdchk(PAB_IDX_B_DIR, 8'h0f);
        rdchk(12'h004, 8'h00);
        chk({31'h0, er}, 32'h1);
        clkOutEn <= 1'b1;
        clkOut <= 1'b1;
        nmiEn <= 1'b1;
        irqEn <= 1'b1;
        cyc(6);
        chk({25'h0, aOe[3:0], aOut[3], nmiIn, irqIn}, 32'h67);
        segEnA <= 8'h0a;
        segEnB <= 8'hf0;
        segOutB <= 8'ha0;
        cyc(6);
        chk({9'h0, aOe[3:0], aOut[3], nmiIn, irqIn, bOe, bOut}, 32'h210fac);
        segEnA <= 8'h01;
        segOutA <= 8'hfe;
        cyc(6);
        chk({29'h0, aOe[3], irqIn, aOut[0]}, 32'h4);
        results;
    end
endmodule
`default_nettype wire
